/* rtl/tersel_edge.sv */
// trigger input synchroniser and selectable edge detector
`timescale 1ns/1ns
module tersel_edge (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic trig_in,
   input wire logic rising_sel,
   output logic edge_pulse
);
   logic sync_a;
   logic sync_b;
   logic prev;

   // ----------------------------------------
   // two-stage synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync_a <= trig_in;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   // one pulse per edge; only sync_b and prev are compared
   always_comb begin
      if (rising_sel) begin
         edge_pulse = sync_b & ~prev;
      end else begin
         edge_pulse = ~sync_b & prev;
      end
   end
endmodule // tersel_edge

/* rtl/tersel_pkg.sv */
// types shared by the trigger and settled-output block
package tersel_pkg;
   typedef enum logic [1:0] {
      TRS_IDLE,
      TRS_HW_WAIT,
      TRS_PROG_WAIT
   } tersel_settle_type;
endpackage

/* rtl/tersel_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TERSEL_REGS_SVH
`define TERSEL_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TRS_OFS_CTRL 12'h000
`define TRS_OFS_SETTLE 12'h004
`define TRS_OFS_CMD 12'h008
`define TRS_OFS_STATUS 12'h00c
`define TRS_OFS_STEP 12'h010

// ----------------------------------------
// control fields
// ----------------------------------------
`define TRS_CTRL_EDGE 0
`define TRS_CTRL_POL 1
`define TRS_CTRL_EXTSRC 2
`define TRS_CTRL_TRGEN 3

// command fields (write-one pulses)
`define TRS_CMD_RELAY 0
`define TRS_CMD_DEFAULTS 1
`define TRS_CMD_CLEAR 2

// status fields
`define TRS_ST_SETTLED 0
`define TRS_ST_BUSY 1

// ----------------------------------------
// reset values and settling limit
// ----------------------------------------
`define TRS_CTRL_RESET 4'h0
`define TRS_SETTLE_RESET 16'h0000
`define TRS_SETTLE_MAX 16'hfde8

// ----------------------------------------
// timing
// ----------------------------------------
`define TRS_CLK_HZ 20000000
`define TRS_MS_PER_S 1000
`define TRS_HW_SETTLE_US 3000
`define TRS_CYC_PER_MS (`TRS_CLK_HZ / `TRS_MS_PER_S)
`define TRS_HW_SETTLE_CYC (`TRS_HW_SETTLE_US * (`TRS_CLK_HZ / 1000000))

`endif

/* rtl/tersel_top.sv */
// trigger edge select, step pointer and settled output with apb registers
`timescale 1ns/1ns
`include "tersel_regs.svh"
//
// Contract
// - fire on falling trigger edge when edge select 0, rising when 1.
// - edge select returns to falling at reset, clears and restore defaults.
// - each accepted external trigger increments the step pointer by one.
// - after incrementing, load the setup the new pointer names onto relays.
// - act on trigger only with external source chosen and triggers enabled.
// - settled pin active-low when polarity select 0, active-high when 1.
// - polarity select returns to active-low at reset, clears, restore defaults.
// - settled output goes false as a relay operation begins.
// - settled returns true only after hardware then programmed settling.
// - any relay-writing operation negates settled, even with no change.
// - polarity affects only the pin; status bit keeps fixed sense.
// - programmed settling is 0 to 65000 ms, added after hardware settling.
module tersel_top #(
   parameter int STEP_W = 7,
   parameter logic [6:0] STEP_MAX = 7'h64,
   parameter int HW_SETTLE_CYC = `TRS_HW_SETTLE_CYC,
   parameter int CYC_PER_MS = `TRS_CYC_PER_MS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_trigger,
   input wire logic device_clear,
   output logic settled_pin,
   output logic settled_status,
   output logic setup_load,
   output logic [STEP_W-1:0] setup_index
);
   import tersel_pkg::*;

   logic trigger_edge_select;
   logic ready_polarity_select;
   logic ext_source;
   logic trig_enable;
   logic [15:0] settle_ms;
   logic [STEP_W-1:0] step;
   logic edge_pulse;
   logic accept;
   logic wr_cmd;
   logic restore_defaults_command;
   logic relay_write;
   logic settled;
   logic [31:0] cyc_cnt;
   logic [15:0] ms_cnt;
   logic [STEP_W-1:0] next_step;
   tersel_settle_type state;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic acc;
   logic wr;
   logic mapped;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   always_comb begin
      case (paddr)
         `TRS_OFS_CTRL, `TRS_OFS_SETTLE, `TRS_OFS_CMD,
         `TRS_OFS_STATUS, `TRS_OFS_STEP: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign wr_cmd = wr & (paddr == `TRS_OFS_CMD);
   // device clear input and the clear command bit act alike
   assign restore_defaults_command = (wr_cmd &
      (pwdata[`TRS_CMD_DEFAULTS] | pwdata[`TRS_CMD_CLEAR])) | device_clear;

   // single-cycle access phase: pready is registered, high for the access cycle only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   // unmapped offsets are refused in the same access cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   // read data is latched at setup, so it stands through the access
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= 32'h0000_0000;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `TRS_OFS_CTRL: prdata <= {28'h0000000, trig_enable,
                  ext_source, ready_polarity_select, trigger_edge_select};
               `TRS_OFS_SETTLE: prdata <= {16'h0000, settle_ms};
               `TRS_OFS_STATUS: prdata <= {30'h00000000,
                  state != TRS_IDLE, settled};
               `TRS_OFS_STEP: prdata <= {{(32-STEP_W){1'b0}}, step};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   // the write lands on the access-phase edge where pready is high
   logic wr_take;
   logic defaults_take;
   logic ctrl_take;
   logic settle_take;
   assign wr_take = wr & pready;
   // defaults also clear source, enable and settling time
   assign defaults_take = restore_defaults_command
      & (wr_take | device_clear);
   assign ctrl_take = wr_take & (paddr == `TRS_OFS_CTRL);
   assign settle_take = wr_take & (paddr == `TRS_OFS_SETTLE);

   // ----------------------------------------
   // configuration
   // ----------------------------------------
   // a new edge choice applies to the next synchronised edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trigger_edge_select <= 1'b0;
      end else if (defaults_take) begin
         trigger_edge_select <= 1'b0;
      end else if (ctrl_take) begin
         trigger_edge_select <= pwdata[`TRS_CTRL_EDGE];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready_polarity_select <= 1'b0;
      end else if (defaults_take) begin
         ready_polarity_select <= 1'b0;
      end else if (ctrl_take) begin
         ready_polarity_select <= pwdata[`TRS_CTRL_POL];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_source <= 1'b0;
      end else if (defaults_take) begin
         ext_source <= 1'b0;
      end else if (ctrl_take) begin
         ext_source <= pwdata[`TRS_CTRL_EXTSRC];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_enable <= 1'b0;
      end else if (defaults_take) begin
         trig_enable <= 1'b0;
      end else if (ctrl_take) begin
         trig_enable <= pwdata[`TRS_CTRL_TRGEN];
      end
   end

   // out-of-range values saturate rather than fault
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settle_ms <= `TRS_SETTLE_RESET;
      end else if (defaults_take) begin
         settle_ms <= `TRS_SETTLE_RESET;
      end else if (settle_take) begin
         if (pwdata[15:0] > `TRS_SETTLE_MAX) begin
            settle_ms <= `TRS_SETTLE_MAX;
         end else begin
            settle_ms <= pwdata[15:0];
         end
      end
   end

   // ----------------------------------------
   // trigger path
   // ----------------------------------------
   tersel_edge u_edge (
      .clk(clk),
      .arst_n(arst_n),
      .trig_in(ext_trigger),
      .rising_sel(trigger_edge_select),
      .edge_pulse(edge_pulse)
   );
   // edges arriving while disabled are dropped, not queued
   assign accept = edge_pulse & ext_source & trig_enable;

   // pointer wraps past the last stored setup back to the first
   always_comb begin
      if (step >= STEP_MAX) begin
         next_step = {{(STEP_W-1){1'b0}}, 1'b1};
      end else begin
         next_step = step + {{(STEP_W-1){1'b0}}, 1'b1};
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         step <= '0;
      end else if (accept) begin
         step <= next_step;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setup_index <= '0;
      end else if (accept) begin
         setup_index <= next_step;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setup_load <= 1'b0;
      end else begin
         setup_load <= accept;
      end
   end

   // ----------------------------------------
   // settling sequence
   // ----------------------------------------
   // software relay writes and trigger loads both count as relay writes
   assign relay_write = (wr_cmd & wr_take & pwdata[`TRS_CMD_RELAY])
      | accept;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= TRS_IDLE;
         cyc_cnt <= 32'h0000_0000;
         ms_cnt <= 16'h0000;
      end else if (relay_write) begin
         // a new write restarts the full wait
         state <= TRS_HW_WAIT;
         cyc_cnt <= 32'h0000_0000;
         ms_cnt <= 16'h0000;
      end else begin
         case (state)
            TRS_IDLE: begin
               cyc_cnt <= 32'h0000_0000;
            end
            TRS_HW_WAIT: begin
               if (cyc_cnt >= 32'(HW_SETTLE_CYC - 1)) begin
                  cyc_cnt <= 32'h0000_0000;
                  state <= TRS_PROG_WAIT;
               end else begin
                  cyc_cnt <= cyc_cnt + 32'h0000_0001;
               end
            end
            TRS_PROG_WAIT: begin
               if (ms_cnt >= settle_ms) begin
                  state <= TRS_IDLE;
               end else if (cyc_cnt >= 32'(CYC_PER_MS - 1)) begin
                  cyc_cnt <= 32'h0000_0000;
                  ms_cnt <= ms_cnt + 16'h0001;
               end else begin
                  cyc_cnt <= cyc_cnt + 32'h0000_0001;
               end
            end
            default: state <= TRS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // settled outputs
   // ----------------------------------------
   assign settled = (state == TRS_IDLE);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settled_status <= 1'b1;
      end else begin
         settled_status <= settled & ~relay_write;
      end
   end

   // a relay write negates the pin on the very next edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         settled_pin <= 1'b0;
      end else begin
         settled_pin <= ~((settled & ~relay_write)
            ^ ready_polarity_select);
      end
   end
endmodule // tersel_top

/* sim/tb_tersel_top.sv */
// testbench for the trigger and settled-output block
`timescale 1ns/1ns
`include "tersel_regs.svh"
module tb_tersel_top;
   logic clk, arst_n, psel, penable, pwrite, ext_trigger, device_clear;
   logic pready, pslverr, settled_pin, settled_status, setup_load, err_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0] setup_index;
   int err_total, n_compared, t0, t2;
   int loads = 0;
   tersel_top #(.HW_SETTLE_CYC(10), .CYC_PER_MS(5))
      u_tersel_top (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_trigger(ext_trigger), .device_clear(device_clear),
      .settled_pin(settled_pin), .settled_status(settled_status),
      .setup_load(setup_load), .setup_index(setup_index));
   tersel_equip u_tersel_equip (.clk(clk), .ext_trigger(ext_trigger),
      .settled_pin(settled_pin));
   // one count per relay load pulse
   always @(posedge clk) begin
      if (setup_load === 1'b1) begin
         loads <= loads + 1;
      end
   end
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ----------------------------------------
   // apb master, released at the edge that answers
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_total++;
         end_sim();
      end
      @(posedge clk);
   endtask
   task automatic settle_time(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (settled_status !== 1'b1 && c < 200);
      if (settled_status !== 1'b1) begin
         err_total++;
         end_sim();
      end
   endtask
   initial begin
      {arst_n, psel, penable, pwrite, device_clear} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_total = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      apb(0, `TRS_OFS_CTRL, 0);
      check(rd, 32'h0);
      check({settled_pin, settled_status}, 32'h1);
      apb(0, 12'h0fc, 0);
      check(err_seen, 1);
      check(rd, 32'h0);
      apb(1, `TRS_OFS_CTRL, 32'h4);
      u_tersel_equip.set_level(1);
      u_tersel_equip.set_level(0);
      apb(0, `TRS_OFS_STEP, 0);
      check(rd, 32'h0);
      apb(1, `TRS_OFS_CTRL, 32'h8);
      u_tersel_equip.set_level(1);
      u_tersel_equip.set_level(0);
      apb(0, `TRS_OFS_STEP, 0);
      check(rd, 32'h0);
      apb(1, `TRS_OFS_CTRL, 32'hc);
      u_tersel_equip.set_level(1);
      apb(0, `TRS_OFS_STEP, 0);
      check(rd, 32'h0);
      u_tersel_equip.set_level(0);
      repeat (2) @(posedge clk);
      check(setup_index, 32'h1);
      settle_time(t0);
      check(t0 > 4, 1);
      apb(1, `TRS_OFS_CTRL, 32'hd);
      // counts up to the last stored setup, then wraps to the first
      for (int i = 2; i <= 101; i++) begin
         u_tersel_equip.set_level(0);
         u_tersel_equip.set_level(1);
         apb(0, `TRS_OFS_STEP, 0);
         check(rd, (i > 100) ? 32'h1 : 32'(i));
      end
      settle_time(t0);
      check(loads, 101);
      apb(1, `TRS_OFS_CMD, 32'h1);
      check({settled_pin, settled_status}, 32'h2);
      settle_time(t0);
      check(t0 > 8, 1);
      apb(1, `TRS_OFS_SETTLE, 32'h2);
      apb(1, `TRS_OFS_CMD, 32'h1);
      settle_time(t2);
      check(t2 - t0, 10);
      apb(1, `TRS_OFS_CTRL, 32'h2);
      repeat (3) @(posedge clk);
      check({settled_pin, settled_status}, 32'h3);
      check(u_tersel_equip.pin_seen, 1);
      apb(1, `TRS_OFS_CMD, 32'h1);
      check({settled_pin, settled_status}, 32'h0);
      apb(0, `TRS_OFS_STATUS, 0);
      check(rd, 32'h2);
      settle_time(t0);
      apb(0, `TRS_OFS_STATUS, 0);
      check(rd, 32'h1);
      for (int k = 0; k < 3; k++) begin
         apb(1, `TRS_OFS_CTRL, 32'h3);
         apb(1, `TRS_OFS_SETTLE, 32'h2);
         if (k == 2) begin
            device_clear <= 1'b1;
            @(posedge clk);
            device_clear <= 1'b0;
            @(posedge clk);
         end else begin
            apb(1, `TRS_OFS_CMD, 32'h2 << k);
         end
         apb(0, `TRS_OFS_CTRL, 0);
         check(rd, 32'h0);
         apb(0, `TRS_OFS_SETTLE, 0);
         check(rd, 32'h0);
      end
      apb(1, `TRS_OFS_SETTLE, 32'hfde9);
      apb(0, `TRS_OFS_SETTLE, 0);
      check(rd, 32'hfde8);
      end_sim();
   end
endmodule // tb_tersel_top

/* sim/tersel_checker.sv */
// port assertions for the trigger and settled-output block
`timescale 1ns/1ns
module tersel_checker #(
   parameter int STEP_W = 7,
   parameter logic [6:0] STEP_MAX = 7'h64
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic settled_status,
   input wire logic setup_load,
   input wire logic [STEP_W-1:0] setup_index
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_answer;
      psel && !penable |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_access;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_access: assert property (p_access) else $error("stray pready");
   property p_err;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("bad refusal");
   property p_step;
      setup_load |-> setup_index == (($past(setup_index) == STEP_MAX) ?
         STEP_W'(1) : $past(setup_index) + STEP_W'(1));
   endproperty
   a_step: assert property (p_step) else $error("step wrong");
   property p_pulse;
      setup_load |=> !setup_load;
   endproperty
   a_pulse: assert property (p_pulse) else $error("load long");
   property p_negate;
      setup_load |-> !settled_status;
   endproperty
   a_negate: assert property (p_negate) else $error("still settled");
   // hardware interval alone is at least this long in the bench
   property p_hold;
      $fell(settled_status) |-> !settled_status [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("settled early");
   property p_once;
      $changed(setup_index) |-> setup_load;
   endproperty
   a_once: assert property (p_once) else $error("index moved alone");
endmodule // tersel_checker
bind tersel_top tersel_checker #(.STEP_W(STEP_W), .STEP_MAX(STEP_MAX))
   u_tersel_checker (.clk(clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .settled_status(settled_status), .setup_load(setup_load),
   .setup_index(setup_index));

/* sim/tersel_equip.sv */
// external test equipment: trigger source and ready sampler
`timescale 1ns/1ns
module tersel_equip (
   input wire logic clk,
   output logic ext_trigger,
   input wire logic settled_pin
);
   logic pin_seen;
   initial begin
      ext_trigger = 1'b0;
   end
   // three cycles per level, well above the minimum width
   task automatic set_level(input logic v);
      ext_trigger <= v;
      repeat (3) @(posedge clk);
   endtask
   always_ff @(posedge clk) begin
      pin_seen <= settled_pin;
   end
endmodule // tersel_equip
